// *** pew_pkg.sv ***
// Constants, types and timing for the parallel memory host controller
// Assumes a 200 MHz core clock
package pew_pkg;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned ADDR_W = 11;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PAGE_LSB_W = 4;
   localparam int unsigned PAGE_BYTES = 16;
   // Interface timing in ns / us / ms
   localparam int unsigned STROBE_NS = 150;
   localparam int unsigned SETUP_NS = 100;
   localparam int unsigned RECOVER_NS = 50;
   localparam int unsigned ACCESS_NS = 300;
   localparam int unsigned FLOAT_NS = 80;
   localparam int unsigned LOAD_WINDOW_US = 20;
   localparam int unsigned PROG_MS = 10;
   localparam int unsigned STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 2;
   localparam int unsigned FLOAT_CYC = (FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Byte loads must begin well inside the window: use half of it
   localparam int unsigned LOAD_WINDOW_CYC = LOAD_WINDOW_US * 1000000 / CLK_PERIOD_PS / 2;
   localparam int unsigned PROG_CYC = PROG_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int unsigned TMR_W = 24;
   localparam logic [1:0] RST_SYNC_INIT = 2'h0;

   typedef enum logic [3:0] {
      PEW_IDLE = 4'h0,
      PEW_WR_SETUP = 4'h1,
      PEW_WR_PULSE = 4'h2,
      PEW_WR_HOLD = 4'h3,
      PEW_RD_WAIT = 4'h4,
      PEW_RD_FLOAT = 4'h5,
      PEW_PROG_WAIT = 4'h6,
      PEW_POLL_GAP = 4'h7
   } pew_state_type;

   typedef struct packed {
      logic sel_n;
      logic gate_n;
      logic strobe_n;
      logic [ADDR_W-1:0] location;
      logic [DATA_W-1:0] wdata;
      logic data_oe;
   } pew_pins_type;

   typedef struct packed {
      logic is_write;
      logic last;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pew_req_type;

   typedef struct packed {
      logic done;
      logic [DATA_W-1:0] rdata;
      logic busy;
   } pew_rsp_type;
endpackage

// *** pew_page_mem.sv ***
// Sixteen-byte page buffer, registered read data
// Assumes one clock and one writer
`timescale 1ns/1ps
module pew_page_mem #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16,
   parameter int unsigned AW = 4
) (
   // Clock
   input wire logic clk_in,
   // Write side
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   // Read side
   input wire logic [AW-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule // pew_page_mem

// *** pew_host.sv ***
// Host controller driving a 2048 x 8 parallel erasable memory
// Assumes the memory pins are on the far side of pads; data input is asynchronous
//
// Operation
// - Write only with select and strobe low and gate high.
// - Host waits the 10 ms programming time unless it polls.
// - One to sixteen bytes may be loaded before programming starts.
// - Host keeps upper location bits fixed during one page load.
// - Each further load starts within 20 us of the previous strobe fall.
// - Host may pulse gate low between page loads, e.g. to poll.
// - Every byte load follows a single write cycle sequence.
// - Select is decoded per device; gate and strobe are shared.
`timescale 1ns/1ps
module pew_host
   import pew_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = PROG_CYC,
   parameter bit USE_POLLING = 1'b1
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // User request
   input wire logic req_valid_in,
   input pew_pkg::pew_req_type req_in,
   output logic req_ready_out,
   output pew_pkg::pew_rsp_type rsp_out,
   // Memory pins
   output pew_pkg::pew_pins_type pins_out,
   input wire logic [pew_pkg::DATA_W-1:0] data_pins_in
);
   import pew_pkg::*;

   typedef struct packed {
      pew_state_type state;
      logic [TMR_W-1:0] tmr;
      logic [TMR_W-1:0] win;
      logic win_run;
      logic [PAGE_LSB_W:0] count;
      logic [ADDR_W-PAGE_LSB_W-1:0] page;
      logic [ADDR_W-1:0] last_addr;
      logic ending;
      logic polling;
      pew_pins_type pins;
      pew_rsp_type rsp;
   } pew_host_state_type;

   pew_host_state_type cur, next_cur;
   logic [1:0] rst_sync;
   logic rst_n;
   logic [DATA_W-1:0] din_meta, din_sync;
   logic [DATA_W-1:0] page_rdata;

   function automatic logic [TMR_W-1:0] cyc(input int unsigned n);
      return TMR_W'(n > 0 ? n - 1 : 0);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and pin input synchroniser
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync <= RST_SYNC_INIT;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   always_ff @(posedge core_clk_in) begin
      din_meta <= data_pins_in;
      din_sync <= din_meta;
   end

   // Page image; read side gives the last written byte for polling
   pew_page_mem #(.WIDTH(DATA_W), .DEPTH(PAGE_BYTES), .AW(PAGE_LSB_W)) u_page (
      .clk_in(core_clk_in),
      .wr_en_in(req_valid_in && req_ready_out && req_in.is_write),
      .wr_addr_in(req_in.addr[PAGE_LSB_W-1:0]),
      .wr_data_in(req_in.data),
      .rd_addr_in(cur.last_addr[PAGE_LSB_W-1:0]),
      .rd_data_out(page_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic in_page;
      logic same_page;
      next_cur = cur;
      in_page = (cur.count != '0);
      same_page = (req_in.addr[ADDR_W-1:PAGE_LSB_W] == cur.page);
      next_cur.rsp.done = 1'b0;
      if (cur.tmr != '0) begin
         next_cur.tmr = cur.tmr - TMR_W'(1);
      end
      // Page window counter since last strobe fall
      if (cur.win_run && cur.win != '0) begin
         next_cur.win = cur.win - TMR_W'(1);
      end
      req_ready_out = 1'b0;
      unique case (cur.state)
         PEW_IDLE: begin
            // Window expired: device now programs on its own
            if (in_page && cur.win_run && cur.win == '0) begin
               next_cur.win_run = 1'b0;
               next_cur.state = PEW_PROG_WAIT;
               // Device may start up to a full window later than us
               next_cur.tmr = cyc(USE_POLLING ? 1 : PROG_CYCLES + 2 * LOAD_WINDOW_CYC);
               next_cur.polling = USE_POLLING;
            end else if (req_valid_in && req_in.is_write &&
                         (!in_page || same_page) &&
                         cur.count != (PAGE_LSB_W+1)'(PAGE_BYTES)) begin
               req_ready_out = 1'b1;
               next_cur.pins.location = req_in.addr;
               next_cur.pins.wdata = req_in.data;
               next_cur.pins.data_oe = 1'b1;
               next_cur.pins.gate_n = 1'b1;
               next_cur.pins.sel_n = 1'b0;
               next_cur.page = req_in.addr[ADDR_W-1:PAGE_LSB_W];
               next_cur.last_addr = req_in.addr;
               next_cur.count = cur.count + (PAGE_LSB_W+1)'(1);
               next_cur.state = PEW_WR_SETUP;
               next_cur.tmr = cyc(SETUP_CYC);
               next_cur.ending = req_in.last;
            end else if (req_valid_in && !req_in.is_write && !in_page) begin
               // Plain read; only when no page load is open, reads between byte loads are avoided for margin
               req_ready_out = 1'b1;
               next_cur.pins.location = req_in.addr;
               next_cur.pins.data_oe = 1'b0;
               next_cur.pins.sel_n = 1'b0;
               next_cur.pins.gate_n = 1'b0;
               next_cur.state = PEW_RD_WAIT;
               next_cur.tmr = cyc(ACCESS_CYC);
            end
         end
         PEW_WR_SETUP: begin
            if (cur.tmr == '0) begin
               // Strobe falls last: address latched here
               next_cur.pins.strobe_n = 1'b0;
               next_cur.win = cyc(LOAD_WINDOW_CYC);
               next_cur.win_run = 1'b1;
               next_cur.state = PEW_WR_PULSE;
               next_cur.tmr = cyc(STROBE_CYC);
            end
         end
         PEW_WR_PULSE: begin
            if (cur.tmr == '0) begin
               // Strobe rises first, data latched here
               next_cur.pins.strobe_n = 1'b1;
               next_cur.state = PEW_WR_HOLD;
               next_cur.tmr = cyc(RECOVER_CYC);
            end
         end
         PEW_WR_HOLD: begin
            if (cur.tmr == '0) begin
               next_cur.pins.sel_n = 1'b1;
               next_cur.pins.data_oe = 1'b0;
               next_cur.rsp.done = 1'b1;
               next_cur.state = PEW_IDLE;
               // Last byte of the page: stop waiting for more loads
               if (cur.ending) begin
                  next_cur.win = '0;
               end
            end
         end
         PEW_RD_WAIT: begin
            if (cur.tmr == '0) begin
               next_cur.rsp.rdata = din_sync;
               next_cur.pins.gate_n = 1'b1;
               next_cur.pins.sel_n = 1'b1;
               next_cur.state = PEW_RD_FLOAT;
               next_cur.tmr = cyc(FLOAT_CYC);
            end
         end
         PEW_RD_FLOAT: begin
            if (cur.tmr == '0) begin
               if (cur.polling) begin
                  // Done once the top line shows the written bit
                  if (cur.rsp.rdata[DATA_W-1] == page_rdata[DATA_W-1]) begin
                     next_cur.polling = 1'b0;
                     next_cur.count = '0;
                     next_cur.rsp.busy = 1'b0;
                     next_cur.state = PEW_IDLE;
                  end else begin
                     next_cur.state = PEW_POLL_GAP;
                     next_cur.tmr = cyc(RECOVER_CYC);
                  end
               end else begin
                  next_cur.rsp.done = 1'b1;
                  next_cur.state = PEW_IDLE;
               end
            end
         end
         PEW_PROG_WAIT: begin
            next_cur.rsp.busy = 1'b1;
            if (cur.tmr == '0) begin
               if (cur.polling) begin
                  next_cur.state = PEW_POLL_GAP;
               end else begin
                  next_cur.count = '0;
                  next_cur.rsp.busy = 1'b0;
                  next_cur.state = PEW_IDLE;
               end
            end
         end
         PEW_POLL_GAP: begin
            if (cur.tmr == '0) begin
               // Poll read of the last written location
               next_cur.pins.location = cur.last_addr;
               next_cur.pins.sel_n = 1'b0;
               next_cur.pins.gate_n = 1'b0;
               next_cur.state = PEW_RD_WAIT;
               next_cur.tmr = cyc(ACCESS_CYC);
            end
         end
         default: begin
            next_cur.state = PEW_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
         cur.pins.sel_n <= 1'b1;
         cur.pins.gate_n <= 1'b1;
         cur.pins.strobe_n <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign pins_out = cur.pins;
   assign rsp_out = cur.rsp;
endmodule // pew_host

// *** pew_host_assertions.sv ***
// Checker for the host controller pins and user handshake
// Assumes it is bound onto pew_host; one clock domain
`timescale 1ns/1ps
module pew_host_assertions
   import pew_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // User side
   input wire logic req_valid_in,
   input pew_pkg::pew_req_type req_in,
   input wire logic req_ready_out,
   input pew_pkg::pew_rsp_type rsp_out,
   // Memory pins
   input pew_pkg::pew_pins_type pins_out,
   input wire logic [pew_pkg::DATA_W-1:0] data_pins_in
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   property p_wr_combo;
      !pins_out.strobe_n |-> !pins_out.sel_n && pins_out.gate_n;
   endproperty
   a_wr_combo: assert property (p_wr_combo) else $error("strobe low outside write");
   property p_no_fight;
      !pins_out.gate_n |-> !pins_out.data_oe;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("data driven during read");
   property p_pulse;
      $fell(pins_out.strobe_n) |-> !pins_out.strobe_n [*4];
   endproperty
   a_pulse: assert property (p_pulse) else $error("strobe pulse too short");
   property p_addr;
      !pins_out.strobe_n |-> $stable(pins_out.location) && !$past(pins_out.sel_n);
   endproperty
   a_addr: assert property (p_addr) else $error("location moved under strobe");
   property p_data;
      $rose(pins_out.strobe_n) |-> pins_out.data_oe && !pins_out.sel_n && $stable(pins_out.wdata);
   endproperty
   a_data: assert property (p_data) else $error("data not held at strobe rise");
   property p_done;
      req_valid_in && req_ready_out && req_in.is_write |-> ##[40:100] rsp_out.done;
   endproperty
   a_done: assert property (p_done) else $error("byte load did not finish");
   property p_busy;
      rsp_out.busy |-> pins_out.strobe_n;
   endproperty
   a_busy: assert property (p_busy) else $error("write while programming");
   property p_read;
      $fell(pins_out.gate_n) |-> !pins_out.sel_n && pins_out.strobe_n;
   endproperty
   a_read: assert property (p_read) else $error("bad read select");
   property p_rst;
      $rose(rst_n_in) |-> (pins_out.sel_n && pins_out.strobe_n && !pins_out.data_oe) [*2];
   endproperty
   a_rst: assert property (p_rst) else $error("pins active after reset");
endmodule // pew_host_assertions

bind pew_host pew_host_assertions pew_host_assertions_i (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
   .req_in(req_in), .req_ready_out(req_ready_out), .rsp_out(rsp_out),
   .pins_out(pins_out), .data_pins_in(data_pins_in));

// *** pew_mem_model.sv ***
// Behavioural erasable memory seen from its pins
// Assumes pins sampled on the host clock
`timescale 1ns/1ps
module pew_mem_model
   import pew_pkg::*;
#(
   parameter int unsigned PROG_T = 300,
   parameter int unsigned WIN_T = 4000
) (
   // Clock and pins
   input wire logic clk_in,
   input pew_pkg::pew_pins_type pins_in,
   output logic [pew_pkg::DATA_W-1:0] dq_out
);
   logic [7:0] mem [2048];
   logic [10:0] a = '0;
   logic [10:0] last_a = '0;
   logic [7:0] last_d = '0;
   logic st_q = 1'b1;
   logic wr_ok;
   int prog = 0, win = 0, lowc = 0, cnt = 0, page_cnt = 0, page_err = 0;
   initial dq_out = 8'h00;
   initial for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
   assign wr_ok = !pins_in.sel_n && pins_in.gate_n;
   always @(posedge clk_in) begin
      st_q <= pins_in.strobe_n;
      lowc <= pins_in.strobe_n ? 0 : lowc + 1;
      if (prog > 0) prog <= prog - 1;
      if (win == 1) begin
         prog <= PROG_T;
         page_cnt <= cnt;
         cnt <= 0;
      end
      if (win > 0) win <= win - 1;
      if (st_q && !pins_in.strobe_n && wr_ok && prog == 0) begin
         a <= pins_in.location;
         win <= WIN_T;
         if ((cnt > 0 && pins_in.location[10:4] != last_a[10:4]) || cnt >= 16)
            page_err <= page_err + 1;
      end
      if (!st_q && pins_in.strobe_n && wr_ok && lowc >= 4 && win > 0) begin
         mem[a] <= pins_in.wdata;
         last_a <= a;
         last_d <= pins_in.wdata;
         cnt <= cnt + 1;
      end
      if (!pins_in.sel_n && !pins_in.gate_n)
         dq_out <= ((prog > 0 || win > 0) && pins_in.location == last_a) ?
            {~last_d[7], last_d[6:0]} : mem[pins_in.location];
      else
         dq_out <= ~dq_out;
   end
endmodule // pew_mem_model

// *** test_pew_host.sv ***
// Self-checking bench for the host controller
// Assumes the behavioural memory model on the pins; 200 MHz clock
`timescale 1ns/1ps
module test_pew_host;
   import pew_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b1;
   logic req_valid_in = 1'b0;
   pew_req_type req_in = '0;
   logic req_ready_out;
   pew_rsp_type rsp_out;
   pew_pins_type pins_out;
   logic [DATA_W-1:0] data_pins_in;
   int error_cnt = 0;
   int total_checks = 0;
   int seen;
   always #2.5 core_clk_in = ~core_clk_in;
   pew_host #(.PROG_CYCLES(100), .USE_POLLING(1'b1)) pew_host_i (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .req_ready_out(req_ready_out), .rsp_out(rsp_out),
      .pins_out(pins_out), .data_pins_in(data_pins_in));
   pew_mem_model pew_mem_model_i (.clk_in(core_clk_in), .pins_in(pins_out), .dq_out(data_pins_in));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string name, logic [31:0] got, logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic send(logic w, logic l, logic [10:0] ad, logic [7:0] d);
      int n;
      int k;
      req_in = '{is_write: w, last: l, addr: ad, data: d};
      req_valid_in = 1'b1;
      for (n = 0; n < 400; n++) begin
         @(negedge core_clk_in);
         if (req_ready_out === 1'b1) break;
      end
      @(posedge core_clk_in);
      #1 req_valid_in = 1'b0;
      for (k = 0; k < 400; k++) begin
         @(posedge core_clk_in);
         #1;
         if (rsp_out.done === 1'b1) break;
      end
      if (n == 400 || k == 400) begin error_cnt++; stop_test(); end
   endtask
   task automatic refused(logic [10:0] ad, output int hits);
      hits = 0;
      req_in = '{is_write: 1'b1, last: 1'b1, addr: ad, data: 8'h00};
      req_valid_in = 1'b1;
      repeat (30) begin
         @(negedge core_clk_in);
         hits += (req_ready_out !== 1'b0);
      end
      @(posedge core_clk_in);
      #1 req_valid_in = 1'b0;
      @(posedge core_clk_in);
      #1;
   endtask
   task automatic wait_busy(logic lvl);
      int n;
      for (n = 0; n < 6000; n++) begin
         @(posedge core_clk_in);
         #1;
         if (rsp_out.busy === lvl) break;
      end
      if (n == 6000) begin error_cnt++; stop_test(); end
   endtask
   task automatic readback(logic [10:0] ad, logic [7:0] exp);
      send(1'b0, 1'b0, ad, 8'h00);
      check("read data", rsp_out.rdata, exp);
   endtask
   task automatic t_byte();
      int n;
      send(1'b1, 1'b1, 11'h7ff, 8'h5a);
      wait_busy(1'b1);
      for (n = 0; n < 400 && pins_out.gate_n !== 1'b0; n++) begin
         @(posedge core_clk_in);
         #1;
      end
      repeat (3) @(posedge core_clk_in);
      #1;
      check("poll bit", data_pins_in[7], 1'b1);
      check("busy mid poll", rsp_out.busy, 1'b1);
      wait_busy(1'b0);
      check("prog left", pew_mem_model_i.prog + pew_mem_model_i.win, 0);
      check("byte count", pew_mem_model_i.page_cnt, 1);
      readback(11'h7ff, 8'h5a);
   endtask
   task automatic t_page();
      for (int i = 0; i < 16; i++) send(1'b1, i == 15, {7'h21, 4'(i)}, 8'hc0 + 8'(i));
      wait_busy(1'b1);
      wait_busy(1'b0);
      check("page count", pew_mem_model_i.page_cnt, 16);
      check("page errors", pew_mem_model_i.page_err, 0);
      readback(11'h210, 8'hc0);
      readback(11'h21f, 8'hcf);
   endtask
   task automatic t_pair();
      send(1'b1, 1'b0, 11'h120, 8'h11);
      refused(11'h230, seen);
      check("other page taken", seen, 0);
      send(1'b1, 1'b1, 11'h121, 8'h12);
      wait_busy(1'b1);
      refused(11'h500, seen);
      check("write while busy", seen, 0);
      wait_busy(1'b0);
      check("pair count", pew_mem_model_i.page_cnt, 2);
      readback(11'h120, 8'h11);
   endtask
   task automatic t_window();
      send(1'b1, 1'b0, 11'h300, 8'h33);
      send(1'b1, 1'b0, 11'h301, 8'h34);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check("window count", pew_mem_model_i.page_cnt, 2);
      readback(11'h301, 8'h34);
   endtask
   initial begin
      #1 rst_n_in = 1'b0;
      repeat (6) @(posedge core_clk_in);
      check("idle pins", {pins_out.sel_n, pins_out.strobe_n, pins_out.data_oe}, 3'h6);
      #1 rst_n_in = 1'b1;
      repeat (3) @(posedge core_clk_in);
      #1;
      t_byte();
      t_page();
      t_pair();
      t_window();
      stop_test();
   end
endmodule // test_pew_host
